// ===== hw/emm_map.vh
// Constants for the embedded memory block: register map, field layout, reset values.
// Assumes inclusion by the block's design files only.
`ifndef EMM_MAP_VH
`define EMM_MAP_VH

// Register byte offsets on the AHB-Lite bus.
`define EMM_CTRL_OFS      8'h00
`define EMM_STAT_OFS      8'h04
`define EMM_ROMA_OFS      8'h08
`define EMM_ROMD_OFS      8'h0c
`define EMM_OFS_MSB       7

// Control register fields.
`define EMM_CTRL_DUAL     0
`define EMM_CTRL_WSEL_LO  1
`define EMM_CTRL_WSEL_HI  2
`define EMM_CTRL_SPLIT    3
`define EMM_CTRL_RDIN     4
`define EMM_CTRL_RWA      5
`define EMM_CTRL_RWE      6
`define EMM_CTRL_RRA      7
`define EMM_CTRL_RRE      8
`define EMM_CTRL_RDOUT    9
`define EMM_CTRL_ROM      10
`define EMM_CTRL_MSB      10
`define EMM_CTRL_RST      11'h3f1

// Status register fields.
`define EMM_STAT_REFUSED  16
`define EMM_STAT_ROM      17

// Width selections: 256x16, 512x8, 1024x4, 2048x2.
`define EMM_W16           2'h0
`define EMM_W8            2'h1
`define EMM_W4            2'h2
`define EMM_W2            2'h3

// Array geometry.
`define EMM_BITS          4096
`define EMM_DW            16
`define EMM_AW            11
`define EMM_ROW_AW        8

`endif

// ===== hw/emm_ram_core.v
// Storage array of the embedded memory block with one write and one read port.
// Assumes one clock; the caller supplies a per-bit write mask.
`timescale 1ns/100ps
module emm_ram_core #(
  parameter DW   = 16,
  parameter AW   = 8,
  parameter ROWS = 256
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [DW-1:0] wmask,
  // Read port
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:ROWS-1];

  // The write strobe is made here from the clock, so callers only meet setup at the edge.
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
  end

  // Reading with a non-blocking assignment returns the old word on a same-row write.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {DW{1'b0}};
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // emm_ram_core

// ===== hw/emm_mem_block.v
// Top of the embedded memory block: configurable RAM or lookup table with AHB-Lite control.
// Assumes one clock hclk; user-side ports are synchronous to it and separate section
// clocks are modelled as clock enables of that one clock.
//
// Functional notes
// - Array holds 4096 bits in total.
// - Single-port or dual-port mode selectable.
// - Write and read sections clocked independently.
// - Each section has its own clock enable.
// - Data words up to 16 bits wide.
// - Loaded pattern acts as 8-in 16-out table.
// - Input and output ports have registers.
// - Alternative: input clock, separate output clock.
// - Shapes 256x16, 512x8, 1024x4, 2048x2.
// - Write strobe generated internally from clock.
// - Each path registered or bypassed independently.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "emm_map.vh"
module emm_mem_block #(
  parameter DW = `EMM_DW,
  parameter AW = `EMM_AW
) (
  // Clock and reset
  input  wire          hclk,
  input  wire          hresetn,
  // AHB-Lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output wire          hreadyout,
  output wire          hresp,
  output reg  [31:0]   hrdata,
  // Write section
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] wr_addr,
  input  wire          wr_en,
  input  wire          wr_clk_en,
  // Read section
  input  wire [AW-1:0] rd_addr,
  input  wire          rd_en,
  input  wire          rd_clk_en,
  // Input and output clock enables for the split scheme
  input  wire          in_clk_en,
  input  wire          out_clk_en,
  // Read data
  output wire [DW-1:0] rd_data
);
  localparam RW = `EMM_ROW_AW;

  reg  [`EMM_CTRL_MSB:0] ctrl_q;
  reg  [RW-1:0]          rom_addr_q;
  reg                    refused_q;
  reg                    dph_q;
  reg                    dwr_q;
  reg                    rwait_q;
  reg  [`EMM_OFS_MSB:0]  dofs_q;
  reg  [DW-1:0]          din_q;
  reg  [AW-1:0]          waddr_q;
  reg                    we_q;
  reg  [AW-1:0]          raddr_q;
  reg                    re_q;
  reg  [1:0]             rsel_q;
  reg  [3:0]             rlane_q;
  reg  [DW-1:0]          dout_q;
  reg  [31:0]            rd_mux;
  wire [DW-1:0]          core_rdata;

  wire       dual   = ctrl_q[`EMM_CTRL_DUAL];
  wire [1:0] wsel   = ctrl_q[`EMM_CTRL_WSEL_HI:`EMM_CTRL_WSEL_LO];
  wire       split  = ctrl_q[`EMM_CTRL_SPLIT];
  wire       rom_md = ctrl_q[`EMM_CTRL_ROM];

  // Section enables: per-section enables, or one for inputs and one for outputs.
  wire ce_w  = split ? in_clk_en  : wr_clk_en;
  wire ce_ri = split ? in_clk_en  : rd_clk_en;
  wire ce_o  = split ? out_clk_en : rd_clk_en;

  // AHB-Lite address phase and data phase tracking.
  wire addr_ok = hsel & htrans[1] & hready;
  wire rd_hold = dph_q & ~dwr_q & ~rwait_q;
  wire bus_wr  = dph_q & dwr_q;

  assign hreadyout = ~rd_hold;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      rwait_q <= 1'b0;
      dofs_q  <= {(`EMM_OFS_MSB+1){1'b0}};
    end else if (rd_hold) begin
      rwait_q <= 1'b1;
    end else begin
      dph_q   <= addr_ok;
      dwr_q   <= hwrite;
      rwait_q <= 1'b0;
      dofs_q  <= haddr[`EMM_OFS_MSB:0];
    end
  end

  // Input path stages; each one is either a register or a bypass.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_q   <= {DW{1'b0}};
      waddr_q <= {AW{1'b0}};
      we_q    <= 1'b0;
      raddr_q <= {AW{1'b0}};
      re_q    <= 1'b0;
    end else begin
      if (ce_w) begin
        din_q   <= wr_data;
        waddr_q <= wr_addr;
        we_q    <= wr_en;
      end
      if (ce_ri) begin
        raddr_q <= rd_addr;
        re_q    <= rd_en;
      end
    end
  end

  wire [DW-1:0] din_e   = ctrl_q[`EMM_CTRL_RDIN] ? din_q   : wr_data;
  wire [AW-1:0] waddr_e = ctrl_q[`EMM_CTRL_RWA]  ? waddr_q : wr_addr;
  wire          we_e    = ctrl_q[`EMM_CTRL_RWE]  ? we_q    : wr_en;
  wire [AW-1:0] raddr_p = ctrl_q[`EMM_CTRL_RRA]  ? raddr_q : rd_addr;
  wire          re_e    = ctrl_q[`EMM_CTRL_RRE]  ? re_q    : rd_en;
  // In single-port mode the one address is the write address.
  wire [AW-1:0] raddr_e = dual ? raddr_p : waddr_e;

  // Row and lane of a word for the selected shape.
  function [RW-1:0] row_of(input [1:0] sel, input [AW-1:0] a);
    reg [AW-1:0] s;
    begin
      s = a >> sel;
      row_of = s[RW-1:0];
    end
  endfunction

  function [3:0] lane_of(input [1:0] sel, input [AW-1:0] a);
    begin
      case (sel)
        `EMM_W8: lane_of = {3'h0, a[0]};
        `EMM_W4: lane_of = {2'h0, a[1:0]};
        `EMM_W2: lane_of = {1'h0, a[2:0]};
        default: lane_of = 4'h0;
      endcase
    end
  endfunction

  function [DW-1:0] mask_of(input [1:0] sel, input [3:0] ln);
    begin
      case (sel)
        `EMM_W8: mask_of = 16'h00ff << {ln[0], 3'h0};
        `EMM_W4: mask_of = 16'h000f << {ln[1:0], 2'h0};
        `EMM_W2: mask_of = 16'h0003 << {ln[2:0], 1'h0};
        default: mask_of = 16'hffff;
      endcase
    end
  endfunction

  function [DW-1:0] spread(input [1:0] sel, input [DW-1:0] d);
    begin
      case (sel)
        `EMM_W8: spread = {2{d[7:0]}};
        `EMM_W4: spread = {4{d[3:0]}};
        `EMM_W2: spread = {8{d[1:0]}};
        default: spread = d;
      endcase
    end
  endfunction

  function [DW-1:0] pick(input [1:0] sel, input [3:0] ln, input [DW-1:0] w);
    reg [DW-1:0] s;
    begin
      s = w & mask_of(sel, ln);
      case (sel)
        `EMM_W8: pick = s >> {ln[0], 3'h0};
        `EMM_W4: pick = s >> {ln[1:0], 2'h0};
        `EMM_W2: pick = s >> {ln[2:0], 1'h0};
        default: pick = s;
      endcase
    end
  endfunction

  // A loaded pattern turns the block into a lookup table: user writes are refused.
  wire user_wr  = we_e & ce_w;
  wire rom_wr   = bus_wr & rom_md & (dofs_q == `EMM_ROMD_OFS);
  wire core_we  = rom_md ? rom_wr : user_wr;
  wire core_re  = re_e & ce_ri;
  wire [RW-1:0] core_wa = rom_md ? rom_addr_q : row_of(wsel, waddr_e);
  wire [DW-1:0] core_wd = rom_md ? hwdata[DW-1:0] : spread(wsel, din_e);
  wire [DW-1:0] core_wm = rom_md ? {DW{1'b1}} : mask_of(wsel, lane_of(wsel, waddr_e));

  emm_ram_core #(
    .DW   (DW),
    .AW   (RW),
    .ROWS (`EMM_BITS / `EMM_DW)
  ) u_core (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (core_we),
    .waddr (core_wa),
    .wdata (core_wd),
    .wmask (core_wm),
    .re    (core_re),
    .raddr (row_of(wsel, raddr_e)),
    .rdata (core_rdata)
  );

  // The lane is remembered with the read so the shape may change without tearing a word.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsel_q  <= `EMM_W16;
      rlane_q <= 4'h0;
    end else if (core_re) begin
      rsel_q  <= wsel;
      rlane_q <= lane_of(wsel, raddr_e);
    end
  end

  wire [DW-1:0] rword = pick(rsel_q, rlane_q, core_rdata);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_q <= {DW{1'b0}};
    end else if (ce_o) begin
      dout_q <= rword;
    end
  end

  assign rd_data = ctrl_q[`EMM_CTRL_RDOUT] ? dout_q : rword;

  // Control, table-load address and refused-write flag.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= `EMM_CTRL_RST;
      rom_addr_q <= {RW{1'b0}};
      refused_q  <= 1'b0;
    end else begin
      if (bus_wr && dofs_q == `EMM_CTRL_OFS) begin
        ctrl_q <= hwdata[`EMM_CTRL_MSB:0];
      end
      if (bus_wr && dofs_q == `EMM_ROMA_OFS) begin
        rom_addr_q <= hwdata[RW-1:0];
      end else if (rom_wr) begin
        rom_addr_q <= rom_addr_q + {{(RW-1){1'b0}}, 1'b1};
      end
      // A refused write in the clearing cycle keeps the flag set.
      if (rom_md && user_wr) begin
        refused_q <= 1'b1;
      end else if (bus_wr && dofs_q == `EMM_STAT_OFS && hwdata[`EMM_STAT_REFUSED]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Read data is captured in the wait cycle so a just-finished write is visible.
  always @* begin
    rd_mux = 32'h0000_0000;
    case (dofs_q)
      `EMM_CTRL_OFS: rd_mux[`EMM_CTRL_MSB:0] = ctrl_q;
      `EMM_STAT_OFS: begin
        rd_mux[DW-1:0]            = rd_data;
        rd_mux[`EMM_STAT_REFUSED] = refused_q;
        rd_mux[`EMM_STAT_ROM]     = rom_md;
      end
      `EMM_ROMA_OFS: rd_mux[RW-1:0] = rom_addr_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_hold) begin
      hrdata <= rd_mux;
    end
  end
endmodule // emm_mem_block

// ===== dv/emm_mem_block_monitor.sv
// Bus handshake and read-hold checks of the embedded memory block.
// Assumes a single slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
module emm_chk #(parameter DW = 16, parameter AW = 11) (
  // Clock and reset
  input wire          hclk,
  input wire          hresetn,
  // Bus
  input wire          hsel,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire          hready,
  input wire          hreadyout,
  input wire          hresp,
  input wire [31:0]   hrdata,
  // User side
  input wire          rd_clk_en,
  input wire          in_clk_en,
  input wire          out_clk_en,
  input wire [DW-1:0] rd_data
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A bus write may switch the output register bypass and so the word shown on rd_data.
  reg wdp_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wdp_q <= 1'b0;
    else wdp_q <= hsel && htrans[1] && hready && hwrite;
  end
  sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  property p_resp; hresp == 1'b0; endproperty
  property p_rd_wait; s_rd |=> s_wait; endproperty
  property p_wr_fast; s_wr |=> hreadyout; endproperty
  property p_low_one; !hreadyout |=> hreadyout; endproperty
  property p_idle; hreadyout && !(hsel && htrans[1] && !hwrite) |=> hreadyout; endproperty
  property p_rdata_chg; $changed(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
  property p_rdata_wr; s_wr |-> ##2 $stable(hrdata)[*2]; endproperty
  property p_hold; !rd_clk_en && !in_clk_en && !out_clk_en && !wdp_q |=> $stable(rd_data);
  endproperty
  a_resp: assert property (p_resp) else $error("Bus response not OKAY.");
  a_rd_wait: assert property (p_rd_wait) else $error("Read wait state wrong.");
  a_wr_fast: assert property (p_wr_fast) else $error("Write was stalled.");
  a_low_one: assert property (p_low_one) else $error("Ready low too long.");
  a_idle: assert property (p_idle) else $error("Ready dropped without a read.");
  a_rdata_chg: assert property (p_rdata_chg) else $error("Read data moved outside a read.");
  a_rdata_wr: assert property (p_rdata_wr) else $error("Read data moved on a write.");
  a_hold: assert property (p_hold) else $error("Read word moved while held.");
endmodule // emm_chk
bind emm_mem_block emm_chk #(.DW(DW), .AW(AW)) emm_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .rd_clk_en(rd_clk_en), .in_clk_en(in_clk_en),
  .out_clk_en(out_clk_en), .rd_data(rd_data));

// ===== dv/emm_user_model.sv
// User-logic model that drives the write and read sections of the memory block.
// Assumes callers enter its tasks just after a rising edge of hclk.
`timescale 1ns/100ps
module emm_user_model (
  // Clock
  input  wire        hclk,
  // Write section
  output reg  [15:0] wr_data,
  output reg  [10:0] wr_addr,
  output reg         wr_en,
  // Read section
  output reg  [10:0] rd_addr,
  output reg         rd_en,
  input  wire [15:0] rd_data
);
  initial begin
    wr_data = 16'h0;
    wr_addr = 11'h0;
    wr_en = 1'b0;
    rd_addr = 11'h0;
    rd_en = 1'b0;
  end
  // Released lines carry the inverse, so a stale value can never pass for a held one.
  task put(input [10:0] a, input [15:0] d);
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge hclk);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
    @(posedge hclk);
  endtask
  task get(input [10:0] a, input integer lat, output [15:0] d);
    rd_addr <= a;
    rd_en <= 1'b1;
    @(posedge hclk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    repeat (lat - 1) @(posedge hclk);
    @(negedge hclk);
    d = rd_data;
    @(posedge hclk);
  endtask
endmodule // emm_user_model

// ===== dv/tb_top.sv
// Self-checking bench of the embedded memory block: AHB-Lite control and user sections.
// Assumes one slave, hready taken from hreadyout, and the unsplit clock-enable scheme outside the split test.
`timescale 1ns/100ps
module tb_top;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg         wr_clk_en;
  reg         rd_clk_en;
  reg         in_clk_en;
  reg         out_clk_en;
  wire        hreadyout;
  wire [31:0] hrdata;
  wire [15:0] wr_data;
  wire [10:0] wr_addr;
  wire        wr_en;
  wire [10:0] rd_addr;
  wire        rd_en;
  wire [15:0] rd_data;
  integer     n_mismatch;
  integer     check_count;
  integer     i;
  reg  [31:0] rv;
  reg  [15:0] ud;
  reg  [10:0] wa;
  reg  [15:0] mem_ref [0:255];
  emm_mem_block emm_mem_block_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .wr_data(wr_data), .wr_addr(wr_addr), .wr_en(wr_en), .wr_clk_en(wr_clk_en),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_clk_en(rd_clk_en), .in_clk_en(in_clk_en),
    .out_clk_en(out_clk_en), .rd_data(rd_data));
  emm_user_model emm_user_model_i (.hclk(hclk), .wr_data(wr_data), .wr_addr(wr_addr),
    .wr_en(wr_en), .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  function [15:0] narrow(input [1:0] sh, input [15:0] d);
    reg [16:0] m;
    begin
      m = (17'h1 << (16 >> sh)) - 17'h1;
      narrow = d & m[15:0];
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ready is looked at mid-cycle, where it holds the value the next rising edge samples.
  task rdy;
    integer n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n = n + 1;
      @(negedge hclk);
    end
    if (n >= 20) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
    rv = hrdata;
    @(posedge hclk);
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wr_clk_en = 1'b1;
    rd_clk_en = 1'b1;
    in_clk_en = 1'b0;
    out_clk_en = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    rv = $urandom(48);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0);
    chk(rv, 32'h3f1);
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rv, 32'h0);
    $display("test regs done");
    for (i = 0; i < 24; i = i + 1) begin
      rv = $urandom;
      mem_ref[rv[7:0]] = rv[23:8];
      emm_user_model_i.put({3'h0, rv[7:0]}, rv[23:8]);
      emm_user_model_i.get({3'h0, rv[7:0]}, 3, ud);
      chk({16'h0, ud}, {16'h0, mem_ref[rv[7:0]]});
    end
    $display("test random done");
    emm_user_model_i.put(11'h5, 16'h1234);
    fork
      emm_user_model_i.put(11'h5, 16'ha5a5);
      emm_user_model_i.get(11'h5, 3, ud);
    join
    chk({16'h0, ud}, 32'h1234);
    emm_user_model_i.get(11'h5, 3, ud);
    chk({16'h0, ud}, 32'ha5a5);
    $display("test collide done");
    wr_clk_en <= 1'b0;
    rd_clk_en <= 1'b0;
    emm_user_model_i.put(11'h5, 16'h0f0f);
    emm_user_model_i.get(11'h6, 3, ud);
    chk({16'h0, ud}, 32'ha5a5);
    wr_clk_en <= 1'b1;
    rd_clk_en <= 1'b1;
    emm_user_model_i.get(11'h5, 3, ud);
    chk({16'h0, ud}, 32'ha5a5);
    $display("test enables done");
    // Split scheme: section enables are off, input and output enables govern instead.
    ahb(1'b1, 8'h00, 32'h3f9);
    wr_clk_en <= 1'b0;
    rd_clk_en <= 1'b0;
    in_clk_en <= 1'b1;
    out_clk_en <= 1'b1;
    emm_user_model_i.put(11'h9, 16'h5a5a);
    emm_user_model_i.get(11'h9, 3, ud);
    chk({16'h0, ud}, 32'h5a5a);
    out_clk_en <= 1'b0;
    emm_user_model_i.put(11'ha, 16'h1111);
    emm_user_model_i.get(11'ha, 3, ud);
    chk({16'h0, ud}, 32'h5a5a);
    out_clk_en <= 1'b1;
    emm_user_model_i.get(11'ha, 3, ud);
    chk({16'h0, ud}, 32'h1111);
    wr_clk_en <= 1'b1;
    rd_clk_en <= 1'b1;
    in_clk_en <= 1'b0;
    out_clk_en <= 1'b0;
    $display("test split done");
    // Single-port: the read follows the write address, not the read address.
    ahb(1'b1, 8'h00, 32'h3f0);
    emm_user_model_i.put(11'hc, 16'h7777);
    fork
      emm_user_model_i.put(11'hc, 16'h2468);
      emm_user_model_i.get(11'h55, 3, ud);
    join
    chk({16'h0, ud}, 32'h7777);
    $display("test single done");
    ahb(1'b1, 8'h00, 32'h1);
    emm_user_model_i.put(11'h7, 16'hc3c3);
    emm_user_model_i.get(11'h7, 1, ud);
    chk({16'h0, ud}, 32'hc3c3);
    $display("test bypass done");
    for (i = 0; i < 4; i = i + 1) begin
      ahb(1'b1, 8'h00, 32'h3f1 | (i[1:0] << 1));
      rv = $urandom;
      wa = (rv[10:0] >> (3 - i[1:0])) & 11'h7fe;
      emm_user_model_i.put(wa, rv[31:16]);
      emm_user_model_i.put(wa + 11'h1, rv[15:0]);
      emm_user_model_i.get(wa, 3, ud);
      chk({16'h0, ud}, {16'h0, narrow(i[1:0], rv[31:16])});
      emm_user_model_i.get(wa + 11'h1, 3, ud);
      chk({16'h0, ud}, {16'h0, narrow(i[1:0], rv[15:0])});
    end
    $display("test shapes done");
    ahb(1'b1, 8'h00, 32'h7f1);
    ahb(1'b1, 8'h08, 32'h40);
    for (i = 0; i < 4; i = i + 1) begin
      rv = $urandom;
      mem_ref[i] = rv[15:0];
      ahb(1'b1, 8'h0c, {16'h0, rv[15:0]});
    end
    emm_user_model_i.put(11'h41, 16'h0);
    for (i = 0; i < 4; i = i + 1) begin
      emm_user_model_i.get(11'h40 | {9'h0, i[1:0]}, 3, ud);
      chk({16'h0, ud}, {16'h0, mem_ref[i]});
    end
    ahb(1'b0, 8'h04, 32'h0);
    chk(rv & 32'h30000, 32'h30000);
    $display("test table done");
    end_sim;
  end
endmodule // tb_top
